/* File: core/pin_mode_pkg.sv */
package pin_mode_pkg;
	localparam logic [11:0] port_b_mode_offset = 12'h000;
	localparam logic [11:0] port_c_mode_offset = 12'h004;
	localparam logic [11:0] port_b_data_offset = 12'h008;
	localparam logic [11:0] port_c_data_offset = 12'h00C;
	localparam logic [11:0] port_b_level_offset = 12'h010;
	localparam logic [11:0] port_c_level_offset = 12'h014;
	localparam logic [7:0] mode_reset = 8'h00;
	localparam logic [3:0] data_reset = 4'h0;
	localparam int pins_per_port = 4;

	typedef enum logic [1:0] {
		mode_input = 2'h0,
		mode_push_pull = 2'h1,
		mode_open_drain = 2'h2,
		mode_pull_up = 2'h3
	} pin_mode_type;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
		logic [3:0] pull_up;
	} pad_ctrl_type;
endpackage

/* File: core/port_pin_mode_config.sv */
// Behaviour
// - A field of 00 makes the pin a plain input with driver off and no pull-up.
// - A field of 01 drives the pin high and low from its output data latch.
// - A field of 10 only pulls low; the first register's bits 7:6..1:0 set pins 3..0.
// - The second register uses the same encoding with bits 7:6..1:0 for pins 3..0.
`timescale 1ns/10ps
module port_pin_mode_config (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] port_b_in,
	input wire logic [3:0] port_c_in,
	output pin_mode_pkg::pad_ctrl_type port_b_pad,
	output pin_mode_pkg::pad_ctrl_type port_c_pad
);
	logic [7:0] port5_low_pin_mode;
	logic [7:0] port6_pin_mode;
	logic [3:0] port_b_data;
	logic [3:0] port_c_data;
	logic [3:0] port_b_level;
	logic [3:0] port_c_level;

	function automatic pin_mode_pkg::pad_ctrl_type decode_pads(input logic [7:0] mode, input logic [3:0] data);
		pin_mode_pkg::pad_ctrl_type p;
		p = '0;
		for (int i = 0; i < pin_mode_pkg::pins_per_port; i++) begin
			unique case (pin_mode_pkg::pin_mode_type'(mode[2*i +: 2]))
				pin_mode_pkg::mode_input: begin
					p.oe[i] = 1'b0;
				end
				pin_mode_pkg::mode_push_pull: begin
					p.out[i] = data[i];
					p.oe[i] = 1'b1;
				end
				pin_mode_pkg::mode_open_drain: begin
					// drives only a low; a high data bit releases the pin
					p.oe[i] = ~data[i];
				end
				pin_mode_pkg::mode_pull_up: begin
					p.pull_up[i] = 1'b1;
				end
			endcase
		end
		return p;
	endfunction

	wire access = psel & penable;
	wire wr = access & pwrite;
	wire setup = psel & ~penable;
	wire hit_b_mode = paddr == pin_mode_pkg::port_b_mode_offset;
	wire hit_c_mode = paddr == pin_mode_pkg::port_c_mode_offset;
	wire hit_b_data = paddr == pin_mode_pkg::port_b_data_offset;
	wire hit_c_data = paddr == pin_mode_pkg::port_c_data_offset;
	wire hit_b_level = paddr == pin_mode_pkg::port_b_level_offset;
	wire hit_c_level = paddr == pin_mode_pkg::port_c_level_offset;
	wire mapped = hit_b_mode | hit_c_mode | hit_b_data | hit_c_data | hit_b_level | hit_c_level;
	// level registers are read only; writing them is an error as well
	wire bad = ~mapped | (pwrite & (hit_b_level | hit_c_level));
	wire [31:0] next_prdata = hit_b_mode ? {24'h000000, port5_low_pin_mode} :
		hit_c_mode ? {24'h000000, port6_pin_mode} :
		hit_b_data ? {28'h0000000, port_b_data} :
		hit_c_data ? {28'h0000000, port_c_data} :
		hit_b_level ? {28'h0000000, port_b_level} :
		hit_c_level ? {28'h0000000, port_c_level} : 32'h00000000;

	assign pready = 1'b1;
	assign pslverr = access & bad;

	// read data caught in the setup cycle so it stands, from a flop, through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= next_prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port5_low_pin_mode <= pin_mode_pkg::mode_reset;
			port6_pin_mode <= pin_mode_pkg::mode_reset;
			port_b_data <= pin_mode_pkg::data_reset;
			port_c_data <= pin_mode_pkg::data_reset;
		end else if (wr) begin
			if (hit_b_mode) begin
				port5_low_pin_mode <= pwdata[7:0];
			end
			if (hit_c_mode) begin
				port6_pin_mode <= pwdata[7:0];
			end
			if (hit_b_data) begin
				port_b_data <= pwdata[3:0];
			end
			if (hit_c_data) begin
				port_c_data <= pwdata[3:0];
			end
		end
	end

	// pin levels sampled so software sees the pads' state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_b_level <= pin_mode_pkg::data_reset;
			port_c_level <= pin_mode_pkg::data_reset;
		end else begin
			port_b_level <= port_b_in;
			port_c_level <= port_c_in;
		end
	end

	// pad controls registered so data outputs come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_b_pad <= '0;
			port_c_pad <= '0;
		end else begin
			port_b_pad <= decode_pads(port5_low_pin_mode, port_b_data);
			port_c_pad <= decode_pads(port6_pin_mode, port_c_data);
		end
	end

	property p_mode_effect(logic [7:0] mode, pin_mode_pkg::pad_ctrl_type pad, logic [3:0] data, int i);
		@(posedge pclk) disable iff (!presetn)
		##1 (pad.oe[i] == (($past(mode[2*i +: 2]) == 2'h1) |
			(($past(mode[2*i +: 2]) == 2'h2) & ~$past(data[i]))));
	endproperty

	property p_pin_effect(logic [7:0] mode, pin_mode_pkg::pad_ctrl_type pad, logic [3:0] data, int i);
		@(posedge pclk) disable iff (!presetn)
		##1 ((pad.out[i] == (($past(mode[2*i +: 2]) == 2'h1) & $past(data[i]))) &&
			(pad.pull_up[i] == ($past(mode[2*i +: 2]) == 2'h3)));
	endproperty

	AST_INPUT_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		port5_low_pin_mode[1:0] == 2'h0 |=> !port_b_pad.oe[0] && !port_b_pad.pull_up[0])
		else $error("input mode pin driven or pulled");
	AST_PUSH_PULL: assert property (@(posedge pclk) disable iff (!presetn)
		port5_low_pin_mode[3:2] == 2'h1 |=> port_b_pad.oe[1] && port_b_pad.out[1] == $past(port_b_data[1]))
		else $error("push-pull pin not following latch");
	AST_OPEN_DRAIN: assert property (@(posedge pclk) disable iff (!presetn)
		port5_low_pin_mode[7:6] == 2'h2 |=> !port_b_pad.out[3] && port_b_pad.oe[3] == !$past(port_b_data[3]))
		else $error("open-drain pin drove high or missed low");
	AST_PORT_C_OE: assert property (p_mode_effect(port6_pin_mode, port_c_pad, port_c_data, 2))
		else $error("port c pin enable wrong for its mode");
	AST_PORT_C_OD: assert property (@(posedge pclk) disable iff (!presetn)
		port6_pin_mode[1:0] == 2'h2 && port_c_data[0] |=> !port_c_pad.oe[0])
		else $error("port c open-drain pin drove high");
	AST_PULL_UP: assert property (@(posedge pclk) disable iff (!presetn)
		port6_pin_mode[5:4] == 2'h3 |=> port_c_pad.pull_up[2] && !port_c_pad.oe[2])
		else $error("pull-up mode wrong");
	AST_RESET_CLEAR: assert property (@(posedge pclk)
		$rose(presetn) |-> port5_low_pin_mode == 8'h00 && port6_pin_mode == 8'h00 && port_b_pad.oe == 4'h0)
		else $error("mode registers not cleared by reset");
	AST_WRITE_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_c_mode |=> port6_pin_mode == $past(pwdata[7:0]) ##1 port_c_pad == decode_pads(
		$past(port6_pin_mode), $past(port_c_data)))
		else $error("mode write not stored or not applied");

	// every pin of both ports, enable (port c pin 2 enable is AST_PORT_C_OE above) and then level and pull-up
	AST_OE_B0: assert property (p_mode_effect(port5_low_pin_mode, port_b_pad, port_b_data, 0))
		else $error("port b pin 0 enable wrong for its mode");
	AST_OE_B1: assert property (p_mode_effect(port5_low_pin_mode, port_b_pad, port_b_data, 1))
		else $error("port b pin 1 enable wrong for its mode");
	AST_OE_B2: assert property (p_mode_effect(port5_low_pin_mode, port_b_pad, port_b_data, 2))
		else $error("port b pin 2 enable wrong for its mode");
	AST_OE_B3: assert property (p_mode_effect(port5_low_pin_mode, port_b_pad, port_b_data, 3))
		else $error("port b pin 3 enable wrong for its mode");
	AST_OE_C0: assert property (p_mode_effect(port6_pin_mode, port_c_pad, port_c_data, 0))
		else $error("port c pin 0 enable wrong for its mode");
	AST_OE_C1: assert property (p_mode_effect(port6_pin_mode, port_c_pad, port_c_data, 1))
		else $error("port c pin 1 enable wrong for its mode");
	AST_OE_C3: assert property (p_mode_effect(port6_pin_mode, port_c_pad, port_c_data, 3))
		else $error("port c pin 3 enable wrong for its mode");
	AST_PIN_B0: assert property (p_pin_effect(port5_low_pin_mode, port_b_pad, port_b_data, 0))
		else $error("port b pin 0 level or pull-up wrong");
	AST_PIN_B1: assert property (p_pin_effect(port5_low_pin_mode, port_b_pad, port_b_data, 1))
		else $error("port b pin 1 level or pull-up wrong");
	AST_PIN_B2: assert property (p_pin_effect(port5_low_pin_mode, port_b_pad, port_b_data, 2))
		else $error("port b pin 2 level or pull-up wrong");
	AST_PIN_B3: assert property (p_pin_effect(port5_low_pin_mode, port_b_pad, port_b_data, 3))
		else $error("port b pin 3 level or pull-up wrong");
	AST_PIN_C0: assert property (p_pin_effect(port6_pin_mode, port_c_pad, port_c_data, 0))
		else $error("port c pin 0 level or pull-up wrong");
	AST_PIN_C1: assert property (p_pin_effect(port6_pin_mode, port_c_pad, port_c_data, 1))
		else $error("port c pin 1 level or pull-up wrong");
	AST_PIN_C2: assert property (p_pin_effect(port6_pin_mode, port_c_pad, port_c_data, 2))
		else $error("port c pin 2 level or pull-up wrong");
	AST_PIN_C3: assert property (p_pin_effect(port6_pin_mode, port_c_pad, port_c_data, 3))
		else $error("port c pin 3 level or pull-up wrong");

	AST_MODE_B_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == pin_mode_pkg::port_b_mode_offset |=> port5_low_pin_mode == $past(pwdata[7:0]))
		else $error("port b mode write not stored");
	AST_DATA_B_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == pin_mode_pkg::port_b_data_offset |=> port_b_data == $past(pwdata[3:0]))
		else $error("port b data latch write not stored");
	AST_DATA_C_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == pin_mode_pkg::port_c_data_offset |=> port_c_data == $past(pwdata[3:0]))
		else $error("port c data latch write not stored");
	AST_READ_DATA: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr == pin_mode_pkg::port_c_mode_offset |=> prdata == {24'h000000, $past(port6_pin_mode)})
		else $error("port c mode read data wrong");
	AST_SLVERR: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && paddr > pin_mode_pkg::port_c_level_offset |-> pslverr)
		else $error("access above the register map not refused");
	// released reset edge leaves the level flop cleared, so the check starts one cycle later
	AST_LEVEL_B: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> port_b_level == $past(port_b_in))
		else $error("port b level not sampled from its pins");
	AST_LEVEL_C: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> port_c_level == $past(port_c_in))
		else $error("port c level not sampled from its pins");

	COV_PUSH_PULL: cover property (@(posedge pclk) wr && hit_b_mode && pwdata[1:0] == 2'h1);
	COV_OPEN_DRAIN_LOW: cover property (@(posedge pclk) port_c_pad.oe[3] && port6_pin_mode[7:6] == 2'h2);
	COV_PULL_UP: cover property (@(posedge pclk) port_b_pad.pull_up == 4'hF);
	COV_BAD_ADDR: cover property (@(posedge pclk) pslverr);
	COV_READ_LEVEL: cover property (@(posedge pclk) access && !pwrite && hit_c_level);
endmodule

/* File: bench/tb_port_pin_mode_config.sv */
`timescale 1ns/10ps
module tb_port_pin_mode_config;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] port_b_in, port_c_in, db, dc, bi, ci;
	logic [7:0] mb, mc;
	pin_mode_pkg::pad_ctrl_type port_b_pad, port_c_pad;
	int err_total, total_checks;
	port_pin_mode_config i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_b_in(port_b_in), .port_c_in(port_c_in),
		.port_b_pad(port_b_pad), .port_c_pad(port_c_pad));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no wait limit here: only the watchdog ends a stuck transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// out stays low unless a push-pull pin drives its latch
	function logic [11:0] exp_pad(input logic [7:0] m, input logic [3:0] d);
		logic [3:0] o, e, p;
		{o, e, p} = 12'h000;
		for (int i = 0; i < 4; i++) begin
			case (m[2*i+:2])
				2'h1: {o[i], e[i]} = {d[i], 1'b1};
				2'h2: e[i] = ~d[i];
				2'h3: p[i] = 1'b1;
				default: ;
			endcase
		end
		return {o, e, p};
	endfunction
	function logic [11:0] pad_of(input pin_mode_pkg::pad_ctrl_type q);
		return {q.out, q.oe, q.pull_up};
	endfunction
	task results;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, port_b_in, port_c_in} = '0;
		{err_total, total_checks} = '0;
		void'($urandom(32'h2A96));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, pin_mode_pkg::port_b_mode_offset, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, pin_mode_pkg::port_c_mode_offset, 32'h0);
		chk(rd, 32'h0);
		chk({8'h00, port_b_pad, port_c_pad}, 32'h00000000);
		$display("reset test done");
		for (int k = 0; k < 24; k++) begin
			mb = (k < 4) ? {4{k[1:0]}} : 8'($urandom);
			mc = (k < 4) ? {4{~k[1:0]}} : 8'($urandom);
			db = (k < 4) ? 4'h5 : 4'($urandom);
			dc = (k < 4) ? 4'hA : 4'($urandom);
			bi = 4'($urandom);
			ci = 4'($urandom);
			port_b_in <= bi;
			port_c_in <= ci;
			apb(1'b1, pin_mode_pkg::port_b_mode_offset, {24'($urandom), mb});
			apb(1'b1, pin_mode_pkg::port_c_mode_offset, {24'($urandom), mc});
			apb(1'b1, pin_mode_pkg::port_b_data_offset, {28'($urandom), db});
			apb(1'b1, pin_mode_pkg::port_c_data_offset, {28'($urandom), dc});
			apb(1'b0, pin_mode_pkg::port_b_mode_offset, 32'h0);
			chk(rd, {24'h0, mb});
			apb(1'b0, pin_mode_pkg::port_c_mode_offset, 32'h0);
			chk(rd, {24'h0, mc});
			apb(1'b0, pin_mode_pkg::port_b_data_offset, 32'h00000000);
			chk(rd, {28'h0000000, db});
			apb(1'b0, pin_mode_pkg::port_c_level_offset, 32'h00000000);
			chk(rd, {28'h0000000, ci});
			chk({31'h00000000, er}, 32'h00000000);
			apb(1'b0, pin_mode_pkg::port_b_level_offset, 32'h00000000);
			chk(rd, {28'h0000000, bi});
			@(posedge pclk);
			chk({20'h00000, pad_of(port_b_pad)}, {20'h00000, exp_pad(mb, db)});
			chk({20'h00000, pad_of(port_c_pad)}, {20'h00000, exp_pad(mc, dc)});
		end
		$display("mode test done");
		apb(1'b1, 12'h018, 32'h000000FF);
		chk({31'h00000000, er}, 32'h00000001);
		apb(1'b1, pin_mode_pkg::port_b_level_offset, 32'h0000000F);
		chk({31'h00000000, er}, 32'h00000001);
		apb(1'b0, 12'h018, 32'h00000000);
		chk({31'h00000000, er}, 32'h00000001);
		chk(rd, 32'h00000000);
		apb(1'b0, pin_mode_pkg::port_b_mode_offset, 32'h00000000);
		chk(rd, {24'h000000, mb});
		$display("unmapped test done");
		// non-zero modes first, so a reset that fails to clear is seen
		apb(1'b1, pin_mode_pkg::port_c_mode_offset, 32'h000000C3);
		apb(1'b1, pin_mode_pkg::port_b_data_offset, 32'h0000000F);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({8'h00, port_b_pad, port_c_pad}, 32'h00000000);
		presetn <= 1'b1;
		apb(1'b0, pin_mode_pkg::port_c_mode_offset, 32'h00000000);
		chk(rd, 32'h00000000);
		apb(1'b0, pin_mode_pkg::port_b_data_offset, 32'h00000000);
		chk(rd, 32'h00000000);
		$display("mid-run reset test done");
		results();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		results();
	end
endmodule
